//--- hw/iem_enable_reg.sv
`timescale 1ns/1ps
`default_nettype none

module iem_enable_reg #(
  parameter iem_pkg::iem_word_t MASK = 16'hFFFF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [1:0] byte_en,
  input wire iem_pkg::iem_word_t wdata,
  input wire iem_pkg::iem_word_t flags,
  output iem_pkg::iem_word_t value,
  output iem_pkg::iem_word_t req
);

  iem_pkg::iem_word_t enable_reg;
  iem_pkg::iem_word_t enable_next;
  iem_pkg::iem_word_t lane_mask;

  // only implemented bits inside written byte lanes can change
  assign lane_mask = {{8{byte_en[1]}}, {8{byte_en[0]}}} & MASK;
  assign enable_next = (enable_reg & ~lane_mask) | (wdata & lane_mask);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= iem_pkg::ENABLE_RESET;
    end else if (wr_en) begin
      enable_reg <= enable_next;
    end
  end

  // the flag passes only where its enable is one; flags themselves are never touched
  assign req = flags & enable_reg & MASK;
  assign value = enable_reg & MASK;

endmodule : iem_enable_reg

`default_nettype wire

//--- hw/iem_interrupt_enable_mask.sv
`timescale 1ns/1ps
`default_nettype none

module iem_interrupt_enable_mask #(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire iem_pkg::iem_bank_s irq_flags,
  output iem_pkg::iem_bank_s irq_req
);

  localparam iem_pkg::iem_word_t MASKS [iem_pkg::BANKS] = '{
    iem_pkg::MASK_0, iem_pkg::MASK_1, iem_pkg::MASK_2,
    iem_pkg::MASK_3, iem_pkg::MASK_4, iem_pkg::MASK_5
  };

  logic [11:0] addr;
  logic [iem_pkg::BANKS-1:0] sel;
  logic sel_pending;
  logic mapped;
  logic wr_access;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [iem_pkg::BANKS*iem_pkg::WORD_W-1:0] flags_flat;
  logic [iem_pkg::BANKS*iem_pkg::WORD_W-1:0] req_flat;
  iem_pkg::iem_word_t values [iem_pkg::BANKS];
  logic [iem_pkg::BANKS-1:0] bank_pending;

  assign addr = 12'(paddr);
  assign flags_flat = irq_flags;
  assign irq_req = req_flat;

  // address decode: one aligned word per register
  always_comb begin
    sel = '0;
    sel_pending = 1'b0;
    if (addr == iem_pkg::OFS_IRQ_ENABLE_0) begin
      sel[0] = 1'b1;
    end else if (addr == iem_pkg::OFS_IRQ_ENABLE_1) begin
      sel[1] = 1'b1;
    end else if (addr == iem_pkg::OFS_IRQ_ENABLE_2) begin
      sel[2] = 1'b1;
    end else if (addr == iem_pkg::OFS_IRQ_ENABLE_3) begin
      sel[3] = 1'b1;
    end else if (addr == iem_pkg::OFS_IRQ_ENABLE_4) begin
      sel[4] = 1'b1;
    end else if (addr == iem_pkg::OFS_IRQ_ENABLE_5) begin
      sel[5] = 1'b1;
    end else if (addr == iem_pkg::OFS_IRQ_PENDING) begin
      sel_pending = 1'b1;
    end
  end

  assign mapped = (|sel) | sel_pending;
  assign wr_access = psel & penable & pwrite;

  // each bank masks its own implemented positions, so the layouts live in the masks
  genvar g;
  generate
    for (g = 0; g < iem_pkg::BANKS; g++) begin : g_bank
      iem_enable_reg #(
        .MASK(MASKS[g])
      ) u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_access & sel[g]),
        .byte_en(pstrb[1:0]),
        .wdata(pwdata[15:0]),
        .flags(flags_flat[g*iem_pkg::WORD_W +: iem_pkg::WORD_W]),
        .value(values[g]),
        .req(req_flat[g*iem_pkg::WORD_W +: iem_pkg::WORD_W])
      );
      assign bank_pending[g] = |req_flat[g*iem_pkg::WORD_W +: iem_pkg::WORD_W];
    end
  endgenerate

  // read data is captured in the setup cycle so that it comes from a flop
  // and the access phase can still finish with no wait state
  always_comb begin
    rdata_next = iem_pkg::RDATA_RESET;
    for (int i = 0; i < iem_pkg::BANKS; i++) begin
      if (sel[i]) begin
        rdata_next = {16'h0000, values[i]};
      end
    end
    if (sel_pending) begin
      rdata_next = {26'h000_0000, bank_pending};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= iem_pkg::RDATA_RESET;
    end else if (psel && !penable && !pwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = 1'b1;
  // unmapped addresses answer with an error and change nothing
  assign pslverr = psel & penable & ~mapped;

endmodule : iem_interrupt_enable_mask

`default_nettype wire

//--- hw/iem_pkg.sv
package iem_pkg;

  localparam int unsigned BANKS = 6;
  localparam int unsigned WORD_W = 16;

  typedef logic [WORD_W-1:0] iem_word_t;

  // one word per enable register, bank 0 in the low word
  typedef struct packed {
    iem_word_t bank5;
    iem_word_t bank4;
    iem_word_t bank3;
    iem_word_t bank2;
    iem_word_t bank1;
    iem_word_t bank0;
  } iem_bank_s;

  // byte addresses on the register bus
  localparam logic [11:0] OFS_IRQ_ENABLE_0 = 12'h000;
  localparam logic [11:0] OFS_IRQ_ENABLE_1 = 12'h004;
  localparam logic [11:0] OFS_IRQ_ENABLE_2 = 12'h008;
  localparam logic [11:0] OFS_IRQ_ENABLE_3 = 12'h00C;
  localparam logic [11:0] OFS_IRQ_ENABLE_4 = 12'h010;
  localparam logic [11:0] OFS_IRQ_ENABLE_5 = 12'h014;
  localparam logic [11:0] OFS_IRQ_PENDING = 12'h018;

  // field positions, enable register 0
  localparam int unsigned EXT_PIN0_IRQ_EN = 0;
  localparam int unsigned CAPTURE1_IRQ_EN = 1;
  // enable register 1
  localparam int unsigned I2C1_SLAVE_IRQ_EN = 0;
  localparam int unsigned I2C1_MASTER_IRQ_EN = 1;
  localparam int unsigned COMPARATOR_IRQ_EN = 2;
  localparam int unsigned CHANGE_NOTIFY_IRQ_EN = 3;
  localparam int unsigned EXT_PIN1_IRQ_EN = 4;
  localparam int unsigned COMPARE3_IRQ_EN = 9;
  localparam int unsigned TIMER4_IRQ_EN = 11;
  localparam int unsigned TIMER5_IRQ_EN = 12;
  localparam int unsigned EXT_PIN2_IRQ_EN = 13;
  localparam int unsigned UART2_RX_IRQ_EN = 14;
  localparam int unsigned UART2_TX_IRQ_EN = 15;
  // enable register 2
  localparam int unsigned SPI2_FAULT_IRQ_EN = 0;
  localparam int unsigned SPI2_EVENT_IRQ_EN = 1;
  localparam int unsigned CAPTURE3_IRQ_EN = 5;
  // enable register 3
  localparam int unsigned I2C2_SLAVE_IRQ_EN = 1;
  localparam int unsigned I2C2_MASTER_IRQ_EN = 2;
  localparam int unsigned CALENDAR_IRQ_EN = 14;
  // enable register 4
  localparam int unsigned UART1_ERROR_IRQ_EN = 1;
  localparam int unsigned UART2_ERROR_IRQ_EN = 2;
  localparam int unsigned CRC_GEN_IRQ_EN = 3;
  localparam int unsigned VOLTAGE_DETECT_IRQ_EN = 8;
  localparam int unsigned CHARGE_TIME_IRQ_EN = 13;
  // enable register 5
  localparam int unsigned LOW_POWER_WAKE_IRQ_EN = 0;

  // implemented-bit masks, derived from the field positions
  localparam iem_word_t MASK_0 = iem_word_t'((1 << EXT_PIN0_IRQ_EN) | (1 << CAPTURE1_IRQ_EN));
  localparam iem_word_t MASK_1 = iem_word_t'((1 << I2C1_SLAVE_IRQ_EN)
    | (1 << I2C1_MASTER_IRQ_EN) | (1 << COMPARATOR_IRQ_EN) | (1 << CHANGE_NOTIFY_IRQ_EN)
    | (1 << EXT_PIN1_IRQ_EN) | (1 << COMPARE3_IRQ_EN) | (1 << TIMER4_IRQ_EN)
    | (1 << TIMER5_IRQ_EN) | (1 << EXT_PIN2_IRQ_EN) | (1 << UART2_RX_IRQ_EN)
    | (1 << UART2_TX_IRQ_EN));
  localparam iem_word_t MASK_2 = iem_word_t'((1 << SPI2_FAULT_IRQ_EN)
    | (1 << SPI2_EVENT_IRQ_EN) | (1 << CAPTURE3_IRQ_EN));
  localparam iem_word_t MASK_3 = iem_word_t'((1 << I2C2_SLAVE_IRQ_EN)
    | (1 << I2C2_MASTER_IRQ_EN) | (1 << CALENDAR_IRQ_EN));
  localparam iem_word_t MASK_4 = iem_word_t'((1 << UART1_ERROR_IRQ_EN)
    | (1 << UART2_ERROR_IRQ_EN) | (1 << CRC_GEN_IRQ_EN) | (1 << VOLTAGE_DETECT_IRQ_EN)
    | (1 << CHARGE_TIME_IRQ_EN));
  localparam iem_word_t MASK_5 = iem_word_t'(1 << LOW_POWER_WAKE_IRQ_EN);

  localparam iem_word_t ENABLE_RESET = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

endpackage : iem_pkg

//--- tb/iem_flag_src.sv
`timescale 1ns/1ps
`default_nettype none
module iem_flag_src (
  input wire logic pclk,
  input wire logic [1:0] mode,
  output iem_pkg::iem_bank_s irq_flags
);
  // mode 2 walks a pattern that changes every cycle, so no stale level hides a fault
  always_ff @(posedge pclk) begin
    case (mode)
      2'h0: irq_flags <= '0;
      2'h1: irq_flags <= '1;
      default: irq_flags <= {irq_flags[94:0], ~irq_flags[95]};
    endcase
  end
endmodule : iem_flag_src
`default_nettype wire

//--- tb/iem_properties.sv
`timescale 1ns/1ps
`default_nettype none
module iem_properties #(parameter int unsigned ADDR_W = 12) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire iem_pkg::iem_bank_s irq_flags,
  input wire iem_pkg::iem_bank_s irq_req
);
  localparam logic [5:0][15:0] MK = {iem_pkg::MASK_5, iem_pkg::MASK_4, iem_pkg::MASK_3,
    iem_pkg::MASK_2, iem_pkg::MASK_1, iem_pkg::MASK_0};
  wire logic [5:0][15:0] rq = irq_req;
  wire logic [5:0][15:0] fl = irq_flags;
  wire logic acc = psel && penable;
  wire logic [2:0] bk = paddr[4:2];
  wire logic hit = paddr < 12'h018;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  req_in_flags_a: assert property ((irq_req & ~irq_flags) == '0)
    else $error("request without its flag");
  req_impl_a: assert property ((rq & ~MK) == '0)
    else $error("request on an unimplemented bit");
  rd_upper_a: assert property (acc |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  rd_unimpl_a: assert property (acc && !pwrite && hit |-> (prdata[15:0] & ~MK[bk]) == '0)
    else $error("unimplemented bit read as one");
  reset_quiet_a: assert property ($rose(presetn) |-> irq_req == '0)
    else $error("request active right after reset");
  req_hold_a: assert property (!(acc && pwrite) ##1 $stable(irq_flags) |-> $stable(irq_req))
    else $error("request moved without cause");
  // one write decides the whole bank, so this ties layout and gating together
  wr_effect_a: assert property (acc && pwrite && hit && pstrb[1:0] == 2'h3 |=>
    rq[$past(bk)] == (fl[$past(bk)] & $past(pwdata[15:0]) & MK[$past(bk)]))
    else $error("written enable not applied to requests");
  // read data only reloads in a read setup cycle, so a refused write may show older data
  unmapped_a: assert property (acc && paddr >= 12'h01C |-> pslverr && (pwrite || prdata == '0))
    else $error("unmapped access not refused");
endmodule : iem_properties
bind iem_interrupt_enable_mask iem_properties #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq_flags,
  .irq_req);
`default_nettype wire

//--- tb/interrupt_enable_mask_test.sv
`timescale 1ns/1ps
`default_nettype none
module interrupt_enable_mask_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic [1:0] mode = 2'h0;
  iem_pkg::iem_bank_s irq_flags, irq_req;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  localparam logic [95:0] MK = {16'h0001, 16'h210E, 16'h4006, 16'h0023, 16'hFA1F, 16'h0003};
  always #10 pclk = ~pclk;
  iem_interrupt_enable_mask u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_flags(irq_flags),
    .irq_req(irq_req));
  iem_flag_src u_src (.pclk(pclk), .mode(mode), .irq_flags(irq_flags));
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(rd, e);
  endtask : rdchk
  task automatic req_chk(input logic [95:0] e);
    @(negedge pclk);
    chk(irq_req, e);
    @(posedge pclk);
  endtask : req_chk
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    mode <= 2'h1;
    @(posedge pclk);
    for (int k = 0; k < 6; k++) rdchk(12'(4 * k), 32'h0);
    req_chk(96'h0);
    $display("reset values done");
    for (int k = 0; k < 6; k++) begin
      xfer(1'b1, 12'(4 * k), 32'h0000FFFF, 4'hF);
      rdchk(12'(4 * k), {16'h0000, MK[16 * k +: 16]});
    end
    req_chk(MK);
    xfer(1'b1, 12'h018, 32'h0, 4'hF);
    chk(er, 1'b0);
    rdchk(12'h018, 32'h0000003F);
    $display("layout done");
    xfer(1'b1, 12'h004, 32'h0, 4'hF);
    req_chk(MK & ~(96'hFFFF << 16));
    xfer(1'b1, 12'h004, 32'h0000FFFF, 4'h1);
    rdchk(12'h004, 32'h0000001F);
    xfer(1'b1, 12'h004, 32'h0000FFFF, 4'h2);
    rdchk(12'h004, 32'h0000FA1F);
    xfer(1'b0, 12'h01C, 32'h0, 4'hF);
    chk({er, rd}, {1'b1, 32'h0});
    xfer(1'b1, 12'h01C, 32'h0000FFFF, 4'hF);
    chk(er, 1'b1);
    $display("masking done");
    mode <= 2'h2;
    repeat (40) @(posedge pclk);
    mode <= 2'h0;
    repeat (2) @(posedge pclk);
    req_chk(96'h0);
    mode <= 2'h1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 6; k++) rdchk(12'(4 * k), 32'h0);
    req_chk(96'h0);
    $display("second reset done");
    tally_and_finish();
  end
endmodule : interrupt_enable_mask_test
`default_nettype wire
